// ==== core/brownout_reset_sequencer.sv ====
// Reset sequencer: supply detectors, power-up timer, clock gating, register file.
// Assumes raw analog detector levels, static fuses and an AXI4-Lite master.
`timescale 1ns/1ps
module brownout_reset_sequencer
  import brownout_reset_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_DELAY_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire brownout_reset_pkg::fuses_t  fuses,
  input  wire brownout_reset_pkg::detectors_t det,
  output logic [1:0]                       brownout_threshold_field,
  output logic                             system_reset_line,
  output logic                             cpu_run,
  output logic                             use_fast_rc,
  output logic                             trap_service_routine,
  output logic                             irq,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import brownout_reset_pkg::*;

  // ---------------------------------------------------------------------------
  // Detector synchronisers
  // ---------------------------------------------------------------------------
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  assign raw_in = {det.por_low, det.bor_below, det.deep_sleep_brownout, det.clock_valid};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        sync1_reg[gi] <= raw_in[gi];
        sync2_reg[gi] <= sync1_reg[gi];
      end
    end
  endgenerate

  logic por_s, bor_s, deep_sleep_brownout_s, clk_ok_s;
  assign {por_s, bor_s, deep_sleep_brownout_s, clk_ok_s} = sync2_reg;

  // ---------------------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------------------
  logic [1:0] brownout_enable_field;
  logic       sbor_reg;
  logic       bor_enabled;
  logic       deep_sleep_brownout_enabled;
  logic       por_cond_s;
  logic       bor_cond_s;
  logic       async_trip;

  assign brownout_enable_field         = fuses.power_on_config_word[BROWNOUT_ENABLE_FIELD_LSB +: 2];
  assign bor_enabled   = (brownout_enable_field != BROWNOUT_ENABLE_FIELD_OFF) &&
                         ((brownout_enable_field != BROWNOUT_ENABLE_FIELD_SOFTWARE) || sbor_reg);
  assign deep_sleep_brownout_enabled = fuses.deep_sleep_config_word[DEEP_SLEEP_BROWNOUT_EN_BIT];
  assign por_cond_s    = por_s || (deep_sleep_brownout_enabled && deep_sleep_brownout_s);
  assign bor_cond_s    = bor_enabled && bor_s;
  assign async_trip    = det.por_low || (deep_sleep_brownout_enabled && det.deep_sleep_brownout) ||
                         (bor_enabled && det.bor_below);

  always_ff @(posedge clk) begin
    brownout_threshold_field <= fuses.power_on_config_word[BROWNOUT_THRESHOLD_FIELD_LSB +: 2];
  end

  // ---------------------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------------------
  seq_state_t             state_reg;
  seq_state_t             state_next;
  logic [POWER_UP_TIMER_CNT_W-1:0]  power_up_timer_cnt_reg;
  logic                   power_up_timer_done;

  assign power_up_timer_done = (power_up_timer_cnt_reg == POWER_UP_TIMER_CNT_W'(POWER_UP_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    if (por_cond_s) begin
      state_next = ST_POR;
    end else if (bor_cond_s) begin
      state_next = ST_BOR;
    end else begin
      unique case (state_reg)
        ST_POR, ST_BOR: begin
          state_next = fuses.power_up_timer_en ? ST_POWER_UP_TIMER : ST_RUN;
        end
        ST_POWER_UP_TIMER: begin
          if (power_up_timer_done) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // The timer is cleared in every state but its own, so a dip restarts it.
  always_ff @(posedge clk) begin
    if (state_reg != ST_POWER_UP_TIMER || state_next != ST_POWER_UP_TIMER) begin
      power_up_timer_cnt_reg <= '0;
    end else begin
      power_up_timer_cnt_reg <= power_up_timer_cnt_reg + POWER_UP_TIMER_CNT_W'(1);
    end
  end

  // Assertion is asynchronous on the raw trip; release is clocked.
  always_ff @(posedge clk or posedge async_trip) begin
    if (async_trip) begin
      system_reset_line <= 1'b1;
    end else if (!nrst) begin
      system_reset_line <= 1'b1;
    end else begin
      system_reset_line <= (state_next != ST_RUN);
    end
  end

  logic in_reset;
  logic por_reset;
  logic bor_entry;
  assign in_reset  = system_reset_line;
  assign por_reset = (state_reg == ST_POR);
  assign bor_entry = (state_reg != ST_BOR) && (state_next == ST_BOR);

  // The oscillator readiness never feeds the sequencer; it gates the CPU and feeds the clock failure monitor.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpu_run <= 1'b0;
    end else begin
      cpu_run <= !in_reset && clk_ok_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock failure monitor and oscillator control
  // ---------------------------------------------------------------------------
  logic [2:0] cur_osc_reg;
  logic       clk_fail_reg;
  logic       clk_fail_evt;

  assign clk_fail_evt = fuses.clock_failure_monitor_en && !in_reset &&
                        !clk_ok_s && !clk_fail_reg;

  always_ff @(posedge clk) begin
    if (!nrst || in_reset) begin
      cur_osc_reg  <= fuses.initial_oscillator_select_fuse;
      use_fast_rc  <= 1'b0;
      trap_service_routine <= 1'b0;
    end else begin
      trap_service_routine <= clk_fail_evt;
      if (clk_fail_evt) begin
        cur_osc_reg <= FRC_OSC_CODE;
        use_fast_rc <= 1'b1;
      end
    end
  end

  // Clock-fail flag clears whenever the system reset line is high.
  always_ff @(posedge clk) begin
    if (in_reset) begin
      clk_fail_reg <= 1'b0;
    end else if (clk_fail_evt) begin
      clk_fail_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        wr_fire;
  logic [15:0] wmask;

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wmask   = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg <= NVM_CONTROL_OFS && aw_addr_reg[1:0] == 2'h0) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [15:0]     reset_control_register_reg;
  logic [EV_W-1:0] ev_status_reg;
  logic [EV_W-1:0] ev_mask_reg;
  logic [15:0]     rtc_cal_reg;
  logic [15:0]     nvm_ctl_reg;
  logic [EV_W-1:0] ev_set;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign sbor_reg = reset_control_register_reg[SBOR_BIT];
  assign ev_set   = {clk_fail_evt, bor_entry};

  always_ff @(posedge clk) begin
    if (por_reset) begin
      reset_control_register_reg <= RESET_CONTROL_RST;
    end else begin
      if (bor_entry) begin
        reset_control_register_reg[BOR_FLAG_BIT] <= 1'b1;
      end
      if (wr_fire && aw_addr_reg == RESET_CONTROL_OFS) begin
        reset_control_register_reg[SBOR_BIT] <= wmask[SBOR_BIT] ? w_data_reg[SBOR_BIT]
                                              : reset_control_register_reg[SBOR_BIT];
        if (w_strb_reg[0] && w_data_reg[POR_FLAG_BIT]) begin
          reset_control_register_reg[POR_FLAG_BIT] <= 1'b0;
        end
        if (w_strb_reg[0] && w_data_reg[BOR_FLAG_BIT] && !bor_entry) begin
          reset_control_register_reg[BOR_FLAG_BIT] <= 1'b0;
        end
      end
    end
  end

  // Status bits: hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!nrst || in_reset) begin
      ev_status_reg <= EV_RST;
      ev_mask_reg   <= EV_RST;
    end else begin
      if (wr_fire && aw_addr_reg == EVENT_STATUS_OFS && w_strb_reg[0]) begin
        ev_status_reg <= (ev_status_reg & ~w_data_reg[EV_W-1:0]) | ev_set;
      end else begin
        ev_status_reg <= ev_status_reg | ev_set;
      end
      if (wr_fire && aw_addr_reg == EVENT_MASK_OFS && w_strb_reg[0]) begin
        ev_mask_reg <= w_data_reg[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (por_reset) begin
      rtc_cal_reg <= RTC_CAL_RST;
      nvm_ctl_reg <= NVM_CONTROL_RST;
    end else if (wr_fire) begin
      if (aw_addr_reg == RTC_CAL_OFS) begin
        rtc_cal_reg <= merge(rtc_cal_reg, w_data_reg[15:0], wmask);
      end
      if (aw_addr_reg == NVM_CONTROL_OFS) begin
        nvm_ctl_reg <= merge(nvm_ctl_reg, w_data_reg[15:0], wmask);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_status_reg & ev_mask_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  logic [15:0] rd_word;
  logic        rd_ok;

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      RESET_CONTROL_OFS: begin
        rd_word = reset_control_register_reg;
        rd_word[SBOR_BIT] = (brownout_enable_field == BROWNOUT_ENABLE_FIELD_SOFTWARE) && sbor_reg;
      end
      EVENT_STATUS_OFS: rd_word[EV_W-1:0] = ev_status_reg;
      EVENT_MASK_OFS:   rd_word[EV_W-1:0] = ev_mask_reg;
      OSC_CONTROL_OFS: begin
        rd_word[COSC_LSB +: 3] = cur_osc_reg;
        rd_word[CF_BIT]        = clk_fail_reg;
      end
      RTC_CAL_OFS:      rd_word = rtc_cal_reg;
      NVM_CONTROL_OFS:  rd_word = nvm_ctl_reg;
      default:          rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // brownout_reset_sequencer

// ==== core/brownout_reset_pkg.sv ====
// Constants, field layouts and carrier types of the brown-out reset sequencer.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package brownout_reset_pkg;

  // ---------------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam logic [7:0]  RESET_CONTROL_OFS = 8'h00;
  localparam logic [7:0]  EVENT_STATUS_OFS  = 8'h04;
  localparam logic [7:0]  EVENT_MASK_OFS    = 8'h08;
  localparam logic [7:0]  OSC_CONTROL_OFS   = 8'h0C;
  localparam logic [7:0]  RTC_CAL_OFS       = 8'h10;
  localparam logic [7:0]  NVM_CONTROL_OFS   = 8'h14;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int SBOR_BIT      = 13;
  localparam int POR_FLAG_BIT  = 0;
  localparam int BOR_FLAG_BIT  = 1;
  localparam int EV_BOR_BIT    = 0;
  localparam int EV_CLKFAIL_BIT = 1;
  localparam int EV_W          = 2;
  localparam int CF_BIT        = 3;
  localparam int COSC_LSB      = 12;
  localparam int DEEP_SLEEP_BROWNOUT_EN_BIT  = 6;
  localparam int BROWNOUT_THRESHOLD_FIELD_LSB      = 5;
  localparam int BROWNOUT_ENABLE_FIELD_LSB     = 0;
  localparam int SYNC_W        = 4;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RESET_CONTROL_RST = 16'h2003;
  localparam logic [15:0] RTC_CAL_RST       = 16'h0000;
  localparam logic [15:0] NVM_CONTROL_RST   = 16'h0000;
  localparam logic [EV_W-1:0] EV_RST        = 2'h0;
  localparam logic [1:0]  BROWNOUT_ENABLE_FIELD_OFF         = 2'h0;
  localparam logic [1:0]  BROWNOUT_ENABLE_FIELD_SOFTWARE    = 2'h1;
  localparam logic [2:0]  FRC_OSC_CODE      = 3'h0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ             = 125;
  localparam int POWER_UP_DELAY_US   = 64;
  localparam int POWER_UP_DELAY_CYC  = POWER_UP_DELAY_US * CLK_MHZ;
  localparam int POWER_UP_TIMER_CNT_W          = 20;

  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_BOR  = 2'b01,
    ST_POWER_UP_TIMER = 2'b10,
    ST_RUN  = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [7:0] power_on_config_word;
    logic [7:0] deep_sleep_config_word;
    logic [2:0] initial_oscillator_select_fuse;
    logic       power_up_timer_en;
    logic       clock_failure_monitor_en;
  } fuses_t;

  typedef struct packed {
    logic por_low;
    logic bor_below;
    logic deep_sleep_brownout;
    logic clock_valid;
  } detectors_t;

endpackage

// ==== dv/brownout_reset_props.sv ====
// Concurrent checks on the reset sequencer's supply, clock and trap outputs.
// Assumes one clock domain and the synchronous active-low reset nrst.
`timescale 1ns/1ps
module brownout_reset_props
  import brownout_reset_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_DELAY_CYC
) (
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire brownout_reset_pkg::fuses_t  fuses,
  input wire brownout_reset_pkg::detectors_t det,
  input wire logic [1:0]                  brownout_threshold_field,
  input wire logic                        system_reset_line,
  input wire logic                        cpu_run,
  input wire logic                        use_fast_rc,
  input wire logic                        trap_service_routine
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence bor_recovers;
    det.bor_below && fuses.power_on_config_word[1] ##1 !det.bor_below;
  endsequence
  sequence por_recovers;
    det.por_low ##1 !det.por_low;
  endsequence

  thr_copy_a: assert property ($past(nrst) |->
    brownout_threshold_field == $past(fuses.power_on_config_word[6:5]))
    else $error("threshold field differs from fuse bits");
  por_trip_a: assert property (det.por_low |-> system_reset_line)
    else $error("supply below power-on level without reset");
  deep_sleep_brownout_trip_a: assert property (
    det.deep_sleep_brownout && fuses.deep_sleep_config_word[6] |-> system_reset_line)
    else $error("deep-sleep trip without reset");
  bor_trip_a: assert property (
    det.bor_below && fuses.power_on_config_word[1] |-> system_reset_line)
    else $error("brown-out without reset");
  por_hold_a: assert property (por_recovers |-> system_reset_line [*2])
    else $error("reset released before detector sync");
  power_up_timer_hold_a: assert property (
    bor_recovers ##0 fuses.power_up_timer_en |-> system_reset_line [*8])
    else $error("power-up delay cut short");
  clk_gate_a: assert property (!det.clock_valid [*4] |-> !cpu_run)
    else $error("cpu runs without a valid clock");
  run_hold_a: assert property (system_reset_line [*2] |-> !cpu_run)
    else $error("cpu runs during reset");
  trap_pulse_a: assert property (trap_service_routine |=> !trap_service_routine)
    else $error("trap longer than one cycle");
  trap_rc_a: assert property (
    trap_service_routine |-> ##[0:1] use_fast_rc && fuses.clock_failure_monitor_en)
    else $error("trap without fallback to fast rc");
  trap_raise_a: assert property ($rose(use_fast_rc) |-> trap_service_routine)
    else $error("fast rc without trap");
endmodule // brownout_reset_props

bind brownout_reset_sequencer brownout_reset_props #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_props (
  .clk(clk), .nrst(nrst), .fuses(fuses), .det(det),
  .brownout_threshold_field(brownout_threshold_field), .system_reset_line(system_reset_line),
  .cpu_run(cpu_run), .use_fast_rc(use_fast_rc), .trap_service_routine(trap_service_routine));

// ==== dv/supply_model.sv ====
// Behavioural supply detectors and oscillator start-up status.
// Assumes the bench sets supply level and oscillator enable at clock edges.
`timescale 1ns/1ps
module supply_model
  import brownout_reset_pkg::*;
#(
  parameter int OST_CYCLES = 30
) (
  input  wire logic                       clk,
  input  wire logic [11:0]                vdd_mv,
  input  wire logic                       osc_on,
  input  wire logic [1:0]                 trip_sel,
  output brownout_reset_pkg::detectors_t  det
);
  // Trip levels in millivolts; the values are arbitrary.
  localparam logic [11:0] POR_MV = 12'h5DC;
  localparam logic [11:0] DS_MV  = 12'h640;
  localparam logic [11:0] BOR_MV = 12'h708;
  logic [7:0] ost_reg;

  // Start-up count runs on its own, unaware of the device reset.
  always_ff @(posedge clk) begin
    if (!osc_on) ost_reg <= 8'h00;
    else if (ost_reg < 8'(OST_CYCLES)) ost_reg <= ost_reg + 8'h01;
  end
  always_comb begin
    det.por_low = vdd_mv < POR_MV;
    det.deep_sleep_brownout = vdd_mv < DS_MV;
    det.bor_below = vdd_mv < (BOR_MV + {2'h0, trip_sel, 8'h00});
    det.clock_valid = ost_reg == 8'(OST_CYCLES);
  end
endmodule // supply_model

// ==== dv/brownout_reset_sequencer_test.sv ====
// Self-checking bench of the brown-out reset sequencer.
// Assumes the supply model drives the detectors; the bench drives fuses and bus.
`timescale 1ns/1ps
module brownout_reset_sequencer_test;
  import brownout_reset_pkg::*;
  localparam int POWER_UP_TIMER = 20;
  localparam logic [11:0] VNOM = 12'hCE4;
  localparam logic [11:0] VDIP = 12'h6A4;
  localparam logic [11:0] VDS  = 12'h60E;
  localparam logic [11:0] VPOR = 12'h4B0;
  localparam logic [2:0]  OSC_FUSE = 3'h5;
  logic        clk, nrst, osc_on;
  logic [11:0] vdd_mv;
  fuses_t      fuses;
  detectors_t  det;
  logic [1:0]  brownout_threshold_field, s_axi_bresp, s_axi_rresp;
  logic        system_reset_line, cpu_run, use_fast_rc, trap_service_routine, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          num_errors, samples_checked, rel_cycles;

  brownout_reset_sequencer #(.POWER_UP_CYCLES(POWER_UP_TIMER)) dut (
    .clk, .nrst, .fuses, .det, .brownout_threshold_field, .system_reset_line, .cpu_run,
    .use_fast_rc, .trap_service_routine, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  supply_model u_supply (.clk, .vdd_mv, .osc_on, .trip_sel(brownout_threshold_field), .det);

  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    num_errors++;
    $display("BAD %s expected done seen timeout", nm);
    end_sim();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!hb) hang("write response");
    chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    for (int n = 0; n < 40 && !hr; n++) begin
      @(negedge clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!hr) hang("read response");
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask
  task automatic boot(input logic [1:0] fld, input logic [1:0] sel, input logic ds,
                      input logic pw, input logic mon, input logic osc);
    @(posedge clk);
    nrst <= 1'b0;
    vdd_mv <= VNOM;
    osc_on <= osc;
    fuses <= {1'b0, sel, 3'h0, fld, 1'b0, ds, 6'h00, OSC_FUSE, pw, mon};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic wait_rst(input logic v, input int lim, output int n);
    for (n = 0; n < lim && system_reset_line !== v; n++) @(negedge clk);
    if (system_reset_line !== v) hang("reset line");
  endtask
  task automatic dip(input logic [11:0] v, input logic e, input string nm);
    @(posedge clk);
    vdd_mv <= v;
    repeat (5) @(negedge clk);
    chk(nm, {31'h0, e}, {31'h0, system_reset_line});
    @(posedge clk);
    vdd_mv <= VNOM;
    wait_rst(1'b0, 60, rel_cycles);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic sc_fields();
    int n;
    for (int i = 0; i < 4; i++) begin
      boot(2'(i), 2'(i), 1'b0, 1'b0, 1'b0, 1'b1);
      wait_rst(1'b0, 40, n);
      chk("threshold", 32'(i), {30'h0, brownout_threshold_field});
      rchk("reset control", RESET_CONTROL_OFS, 32'hFFFF, {18'h0, i == 1, 13'h0003});
      rchk("osc reset", OSC_CONTROL_OFS, 32'h7008, {17'h0, OSC_FUSE, 12'h000});
      dip(VDIP, i != 0, "brown-out reset");
      chk("fast release", 32'h1, {31'h0, rel_cycles < POWER_UP_TIMER});
    end
  endtask
  task automatic sc_soft();
    boot(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(RTC_CAL_OFS, 32'h1234);
    wr(RESET_CONTROL_OFS, 32'h2003);
    dip(VDIP, 1'b1, "soft brown-out on");
    rchk("rtc kept", RTC_CAL_OFS, 32'hFFFF, 32'h1234);
    rchk("brown-out kind", RESET_CONTROL_OFS, 32'hFFFF, 32'h2002);
    wr(RESET_CONTROL_OFS, 32'h0003);
    rchk("soft bit", RESET_CONTROL_OFS, 32'h2000, 32'h0);
    dip(VDIP, 1'b0, "soft brown-out off");
  endtask
  task automatic sc_por();
    logic [31:0] d;
    logic [1:0] r;
    boot(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(RTC_CAL_OFS, 32'h1234);
    wr(NVM_CONTROL_OFS, 32'h0055);
    rchk("nvm written", NVM_CONTROL_OFS, 32'hFFFF, 32'h0055);
    dip(VPOR, 1'b1, "power-on reset");
    rchk("rtc cleared", RTC_CAL_OFS, 32'hFFFF, 32'h0);
    rchk("nvm cleared", NVM_CONTROL_OFS, 32'hFFFF, 32'h0);
    rchk("reset control", RESET_CONTROL_OFS, 32'hFFFF, 32'h2003);
    rd(8'h40, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask
  task automatic sc_power_up_timer();
    int n;
    boot(2'h3, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    wait_rst(1'b0, 60, n);
    @(posedge clk);
    vdd_mv <= VDIP;
    repeat (3) @(posedge clk);
    vdd_mv <= VNOM;
    repeat (12) @(posedge clk);
    vdd_mv <= VDIP;
    repeat (3) @(posedge clk);
    vdd_mv <= VNOM;
    wait_rst(1'b0, 60, n);
    chk("delay restart", 32'h1, {31'h0, n >= POWER_UP_TIMER});
  endtask
  task automatic sc_deep();
    for (int j = 0; j < 2; j++) begin
      boot(2'h0, 2'h0, j[0], 1'b0, 1'b0, 1'b1);
      dip(VDS, j[0], "deep-sleep trip");
    end
  endtask
  task automatic sc_clock();
    int n;
    boot(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_rst(1'b0, 40, n);
    repeat (8) @(negedge clk);
    chk("cpu held", 32'h0, {31'h0, cpu_run});
    chk("fast rc", 32'h1, {31'h0, use_fast_rc});
    rchk("osc control", OSC_CONTROL_OFS, 32'h7008, {17'h0, FRC_OSC_CODE, 12'h008});
    rchk("clock event", EVENT_STATUS_OFS, 32'h3, 32'h2);
    wr(EVENT_MASK_OFS, 32'h2);
    repeat (2) @(negedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    @(posedge clk);
    osc_on <= 1'b1;
    for (n = 0; n < 60 && cpu_run !== 1'b1; n++) @(negedge clk);
    chk("cpu run", 32'h1, {31'h0, cpu_run});
    wr(EVENT_STATUS_OFS, 32'h2);
    repeat (2) @(negedge clk);
    chk("irq off", 32'h0, {31'h0, irq});
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    vdd_mv = VNOM;
    osc_on = 1'b0;
    fuses = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    sc_fields();
    sc_soft();
    sc_por();
    sc_power_up_timer();
    sc_deep();
    sc_clock();
    end_sim();
  end
endmodule // brownout_reset_sequencer_test
